/* src/rxa_irq.sv */
// Purpose: receive-side far-end failure, app-id and parity interrupts
// Assumes: framer inputs come from logic on sys_clk; AHB-Lite slave
// Notes: zero wait states; status flags clear on read or write-one
//
// How it works
// - Frames with both X bits zero declare the far-end failure state.
// - Frames whose X bits are not both zero clear that state.
// - Failure change interrupt fires on both declare and clear when enabled.
// - Failure change enable is read/write bit 3 of register 0x12.
// - Enable bit one allows its interrupt, zero blocks it.
// - Failure change sets bit 3 of the status register 0x13.
// - Any enabled event drives the interrupt output high unless it meets a read of 0x13, which returns it instead.
// - Register 0x11 holds block error bits 2..0, app-id 3, failure 4.
// - A change of the app-id bit raises an interrupt when enabled.
// - App-id change enable is read/write bit 2 of register 0x12.
// - App-id change sets status bit 2 of register 0x13.
// - Each parity-bit error raises an interrupt when enabled.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "rxa_regs.svh"

module rxa_irq
  import rxa_pkg::*;
#(
  parameter int CNT_W = 4,
  parameter int FAIL_SET_FRAMES = `RXA_FAIL_SET_FRAMES,
  parameter int FAIL_CLR_FRAMES = `RXA_FAIL_CLR_FRAMES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Receive framer overhead, one frame per frame_done pulse
  input wire logic rx_frame_done,
  input wire logic [1:0] rx_x_bits,
  input wire logic rx_app_id_bit,
  input wire logic [2:0] rx_febe,
  input wire logic rx_pbit_err,
  // Interrupt request
  output logic irq
);

  // Framer inputs grouped
  rxa_frame_t frm;
  assign frm = '{frame_done: rx_frame_done, x_bits: rx_x_bits,
                 app_id: rx_app_id_bit, febe: rx_febe,
                 pbit_err: rx_pbit_err};

  // Alarm state
  logic far_end_fail_now;
  logic app_id_bit_now;
  logic [2:0] far_end_block_err_val;
  logic [CNT_W-1:0] set_cnt;
  logic [CNT_W-1:0] clr_cnt;
  logic next_far_end_fail_now;
  logic next_app_id_bit_now;
  logic [2:0] next_febe;
  logic [CNT_W-1:0] next_set_cnt;
  logic [CNT_W-1:0] next_clr_cnt;

  // Registers
  logic [7:0] rx_event_irq_enable;
  logic [7:0] rx_event_irq_flags;
  logic [7:0] next_enable;
  logic [7:0] next_flags;
  logic [7:0] merged_flags;
  logic [7:0] w1c_mask;
  logic [7:0] ev_raw;
  logic [7:0] ev_set;
  logic [7:0] alarm_state;

  // Bus
  rxa_aphase_t aph;
  rxa_aphase_t next_aph;
  rxa_reg_sel_t aph_sel;
  rxa_reg_sel_t dph_sel;
  logic [31:0] next_hrdata;
  logic addr_take;
  logic rd_take;
  logic wr_commit;
  logic rd_flags;
  logic [7:0] rd_byte;

  // ------------------------------------------------------------------
  // Far-end failure detection
  // ------------------------------------------------------------------
  // Separate declare and clear runs give a little persistence when the
  // frame counts are raised; at one frame each the state tracks the X bits.
  logic x_zero;
  logic run_set_done;
  logic run_clr_done;

  assign x_zero = (frm.x_bits == 2'b00);

  assign run_set_done =
    (32'(set_cnt) + 32'd1 >= 32'(FAIL_SET_FRAMES));
  assign run_clr_done =
    (32'(clr_cnt) + 32'd1 >= 32'(FAIL_CLR_FRAMES));

  always_comb begin
    next_far_end_fail_now = far_end_fail_now;
    next_set_cnt = set_cnt;
    next_clr_cnt = clr_cnt;
    if (frm.frame_done) begin
      if (x_zero) begin
        next_clr_cnt = '0;
        if (!far_end_fail_now) begin
          if (run_set_done) begin
            next_far_end_fail_now = 1'b1;
            next_set_cnt = '0;
          end else begin
            next_set_cnt = set_cnt + 1'b1;
          end
        end
      end else begin
        next_set_cnt = '0;
        if (far_end_fail_now) begin
          if (run_clr_done) begin
            next_far_end_fail_now = 1'b0;
            next_clr_cnt = '0;
          end else begin
            next_clr_cnt = clr_cnt + 1'b1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // App-id bit and block error value, sampled once per frame
  // ------------------------------------------------------------------
  assign next_app_id_bit_now =
    frm.frame_done ? frm.app_id : app_id_bit_now;
  assign next_febe =
    frm.frame_done ? frm.febe : far_end_block_err_val;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      far_end_fail_now <= 1'b0;
      app_id_bit_now <= 1'b0;
      far_end_block_err_val <= `RXA_RST_FEBE;
      set_cnt <= '0;
      clr_cnt <= '0;
    end else begin
      far_end_fail_now <= next_far_end_fail_now;
      app_id_bit_now <= next_app_id_bit_now;
      far_end_block_err_val <= next_febe;
      set_cnt <= next_set_cnt;
      clr_cnt <= next_clr_cnt;
    end
  end

  // ------------------------------------------------------------------
  // Events
  // ------------------------------------------------------------------
  // Both edges of the failure state count as one event kind.
  // The app-id reset value is zero, so a first frame carrying one
  // reports a change; software then reads the state anyway.
  always_comb begin
    ev_raw = 8'h00;
    ev_raw[`RXA_EV_FAIL] =
      (next_far_end_fail_now != far_end_fail_now);
    ev_raw[`RXA_EV_APP_ID] =
      (next_app_id_bit_now != app_id_bit_now);
    ev_raw[`RXA_EV_PBIT] = frm.pbit_err;
  end

  // Only enabled events are latched
  assign ev_set = ev_raw & rx_event_irq_enable;

  // ------------------------------------------------------------------
  // AHB-Lite address phase
  // ------------------------------------------------------------------
  assign addr_take = hsel && htrans[1] && hready;
  assign rd_take = addr_take && !hwrite;

  assign next_aph = addr_take ?
    rxa_aphase_t'{valid: 1'b1, write: hwrite,
                  addr: haddr[`RXA_ADDR_W-1:0]} :
    (hready ? rxa_aphase_t'{valid: 1'b0, write: 1'b0, addr: '0} : aph);

  // Upper address bits must be zero for a hit
  logic hi_zero;
  assign hi_zero = (haddr[31:`RXA_ADDR_W] == '0);

  assign aph_sel =
    !hi_zero ? RXA_REG_NONE :
    (haddr[`RXA_ADDR_W-1:0] == `RXA_ADDR_STATE) ? RXA_REG_STATE :
    (haddr[`RXA_ADDR_W-1:0] == `RXA_ADDR_ENABLE) ? RXA_REG_ENABLE :
    (haddr[`RXA_ADDR_W-1:0] == `RXA_ADDR_FLAGS) ? RXA_REG_FLAGS :
    RXA_REG_NONE;

  // ------------------------------------------------------------------
  // AHB-Lite data phase: writes commit at the end of it
  // ------------------------------------------------------------------
  assign dph_sel =
    (aph.addr == `RXA_ADDR_STATE) ? RXA_REG_STATE :
    (aph.addr == `RXA_ADDR_ENABLE) ? RXA_REG_ENABLE :
    (aph.addr == `RXA_ADDR_FLAGS) ? RXA_REG_FLAGS :
    RXA_REG_NONE;

  // aph.addr only holds low bits, so recheck the high ones at capture
  logic aph_hit;
  assign wr_commit = aph.valid && aph.write && aph_hit && hready;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aph <= '{valid: 1'b0, write: 1'b0, addr: '0};
      aph_hit <= 1'b0;
    end else begin
      aph <= next_aph;
      if (addr_take) begin
        aph_hit <= hi_zero;
      end
    end
  end

  // ------------------------------------------------------------------
  // Enable register
  // ------------------------------------------------------------------
  // All eight bits store; only 3, 2 and 0 steer events in this block.
  assign next_enable =
    (wr_commit && dph_sel == RXA_REG_ENABLE) ?
    hwdata[7:0] : rx_event_irq_enable;

  // ------------------------------------------------------------------
  // Flag register: set wins over write-one clear; a read clears all bits, new sets too
  // ------------------------------------------------------------------
  assign w1c_mask =
    (wr_commit && dph_sel == RXA_REG_FLAGS) ? hwdata[7:0] : 8'h00;

  assign rd_flags = rd_take && (aph_sel == RXA_REG_FLAGS);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      // Bits 7..4 and 1 have no source here and stay zero
      assign merged_flags[gi] =
        ev_set[gi] || (rx_event_irq_flags[gi] && !w1c_mask[gi]);
      // A read returns merged_flags, so clearing them loses nothing
      assign next_flags[gi] =
        rd_flags ? ev_set[gi] && 1'b0 : merged_flags[gi];
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_event_irq_enable <= `RXA_RST_ENABLE;
      rx_event_irq_flags <= `RXA_RST_FLAGS;
    end else begin
      rx_event_irq_enable <= next_enable;
      rx_event_irq_flags <= next_flags;
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  // Read values come from next_ terms so a write in the preceding data
  // phase is already visible; reserved bits read zero.
  always_comb begin
    alarm_state = 8'h00;
    alarm_state[`RXA_ST_FEBE_MSB:`RXA_ST_FEBE_LSB] = next_febe;
    alarm_state[`RXA_ST_APP_ID] = next_app_id_bit_now;
    alarm_state[`RXA_ST_FAIL] = next_far_end_fail_now;
  end

  assign rd_byte =
    (aph_sel == RXA_REG_STATE) ? alarm_state :
    (aph_sel == RXA_REG_ENABLE) ? next_enable :
    (aph_sel == RXA_REG_FLAGS) ? merged_flags :
    8'h00;

  assign next_hrdata = rd_take ? {24'h000000, rd_byte} : hrdata;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // Zero wait states and no error answers
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ------------------------------------------------------------------
  // Interrupt output
  // ------------------------------------------------------------------
  // Masked again at the output so clearing an enable drops a pending
  // request without touching its flag.
  assign irq =
    |(rx_event_irq_flags & rx_event_irq_enable);

  // hsize is accepted but only whole words are meaningful
  logic unused_size;
  assign unused_size = ^hsize;

endmodule // rxa_irq

/* src/rxa_regs.svh */
// Purpose: register map, field positions, reset values and frame counts
// Assumes: included by bare name from rxa_pkg and the design file
// Notes: printed offsets are word indices; byte address is four times one
`ifndef RXA_REGS_SVH
`define RXA_REGS_SVH

// Register indices as printed
`define RXA_IDX_STATE 8'h11
`define RXA_IDX_ENABLE 8'h12
`define RXA_IDX_FLAGS 8'h13

// Byte addresses on the bus
`define RXA_ADDR_STATE 12'h044
`define RXA_ADDR_ENABLE 12'h048
`define RXA_ADDR_FLAGS 12'h04C
`define RXA_ADDR_W 12

// Fields of rx_alarm_state
`define RXA_ST_FEBE_LSB 0
`define RXA_ST_FEBE_MSB 2
`define RXA_ST_APP_ID 3
`define RXA_ST_FAIL 4

// Event bits shared by rx_event_irq_enable and rx_event_irq_flags
`define RXA_EV_PBIT 0
`define RXA_EV_APP_ID 2
`define RXA_EV_FAIL 3

// Reset values
`define RXA_RST_ENABLE 8'h00
`define RXA_RST_FLAGS 8'h00
`define RXA_RST_FEBE 3'h0

// Frames needed to declare and to clear the far-end failure state
`define RXA_FAIL_SET_FRAMES 1
`define RXA_FAIL_CLR_FRAMES 1

`endif

/* src/rxa_pkg.sv */
// Purpose: types shared by the receive alarm interrupt block
// Assumes: constants live in rxa_regs.svh
// Notes: none
`include "rxa_regs.svh"

package rxa_pkg;

  // One received frame's overhead as seen by the framer
  typedef struct packed {
    logic frame_done;
    logic [1:0] x_bits;
    logic app_id;
    logic [2:0] febe;
    logic pbit_err;
  } rxa_frame_t;

  // AHB-Lite address phase held into the data phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [`RXA_ADDR_W-1:0] addr;
  } rxa_aphase_t;

  typedef enum logic [1:0] {
    RXA_REG_NONE,
    RXA_REG_STATE,
    RXA_REG_ENABLE,
    RXA_REG_FLAGS
  } rxa_reg_sel_t;

endpackage

/* dv/rxa_irq_sva.sv */
// Purpose: port checker for rxa_irq
// Assumes: one slave, zero wait states
// Notes: shadows enable and framer state from the ports
`timescale 1ns/100ps
module rxa_irq_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Framer and interrupt
  input wire logic rx_frame_done,
  input wire logic [1:0] rx_x_bits,
  input wire logic rx_app_id_bit,
  input wire logic [2:0] rx_febe,
  input wire logic rx_pbit_err,
  input wire logic irq
);
  logic [7:0] en;
  logic [2:0] febe;
  logic fail;
  logic app;
  logic en_wr;
  wire tk = hsel & htrans[1] & hready;
  wire rd_en = tk & !hwrite & (haddr == 32'h48);
  wire rd_st = tk & !hwrite & (haddr == 32'h44) & !rx_frame_done;
  wire rd_fl = tk & !hwrite & (haddr == 32'h4C);
  wire quiet = !rx_frame_done & !rx_pbit_err;
  wire fail_chg = rx_frame_done & ((rx_x_bits == 2'h0) != fail);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk) begin
    en_wr <= !rst & tk & hwrite & (haddr == 32'h48);
    if (rst) begin
      en <= 8'h00;
      {fail, app, febe} <= 5'h00;
    end else begin
      if (en_wr) en <= hwdata[7:0];
      if (rx_frame_done)
        {fail, app, febe} <= {rx_x_bits == 2'h0, rx_app_id_bit, rx_febe};
    end
  end
  a_fail_irq: assert property (en[3] && fail_chg |=> irq)
    else $error("fail change gave no irq");
  a_app_irq: assert property (
    en[2] && rx_frame_done && rx_app_id_bit != app |=> irq)
    else $error("app id change gave no irq");
  a_pbit_irq: assert property (en[0] && rx_pbit_err |=> irq)
    else $error("parity error gave no irq");
  a_mask_quiet: assert property ((en & 8'h0D) == 8'h00 |-> !irq)
    else $error("irq while all disabled");
  a_state_read: assert property (
    rd_st |=> hrdata == {27'h0, fail, app, febe})
    else $error("state read wrong");
  a_enable_read: assert property (rd_en |=> hrdata == {24'h0, en})
    else $error("enable read wrong");
  a_read_clear: assert property (rd_fl && quiet |=> !irq)
    else $error("irq after flag read");
  a_flag_bits: assert property (
    rd_fl |=> hrdata[31:4] == 28'h0 && !hrdata[1])
    else $error("unused flag bit set");
  cover property (rd_fl && irq);
  cover property (en[3] && fail_chg);
  cover property (en[0] && rx_pbit_err);
endmodule // rxa_irq_sva

bind rxa_irq rxa_irq_sva chk (.sys_clk, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .rx_frame_done, .rx_x_bits,
  .rx_app_id_bit, .rx_febe, .rx_pbit_err, .irq);

/* dv/rxa_framer_model.sv */
// Purpose: receive framer stand-in feeding frame overhead
// Assumes: tasks are called just after a rising edge
// Notes: fields are inverted between frames so stale use shows
`timescale 1ns/100ps
module rxa_framer_model (
  // Clock
  input wire logic sys_clk,
  // Overhead to the block
  output logic rx_frame_done = 1'h0,
  output logic [1:0] rx_x_bits = 2'h3,
  output logic rx_app_id_bit = 1'h0,
  output logic [2:0] rx_febe = 3'h0,
  output logic rx_pbit_err = 1'h0
);
  task automatic frame(input logic [1:0] x, input logic a,
    input logic [2:0] f);
    @(posedge sys_clk);
    rx_frame_done <= 1'h1;
    rx_x_bits <= x;
    rx_app_id_bit <= a;
    rx_febe <= f;
    @(posedge sys_clk);
    rx_frame_done <= 1'h0;
    rx_x_bits <= ~x;
    rx_app_id_bit <= ~a;
    rx_febe <= ~f;
  endtask
  task automatic perr;
    @(posedge sys_clk);
    rx_pbit_err <= 1'h1;
    @(posedge sys_clk);
    rx_pbit_err <= 1'h0;
  endtask
endmodule // rxa_framer_model

/* dv/rxa_irq_test.sv */
// Purpose: register and interrupt tests for rxa_irq
// Assumes: hready fed back from hreadyout, one slave
// Notes: expectations come from the register layout
`timescale 1ns/100ps
module rxa_irq_test;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] got;
  wire hready, hresp, irq, rx_frame_done, rx_app_id_bit, rx_pbit_err;
  wire [31:0] hrdata;
  wire [1:0] rx_x_bits;
  wire [2:0] rx_febe;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  rxa_framer_model fr (.sys_clk, .rx_frame_done, .rx_x_bits,
    .rx_app_id_bit, .rx_febe, .rx_pbit_err);
  rxa_irq uut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
    .rx_frame_done, .rx_x_bits, .rx_app_id_bit, .rx_febe, .rx_pbit_err,
    .irq);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w,
    input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge sys_clk);
    while (hready !== 1'h1) @(posedge sys_clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'h1) @(posedge sys_clk);
    got = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, exp, input string what);
    xfer(a, 1'h0, 32'h0);
    chk(got, exp, what);
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask
  task automatic irq_is(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e}, "irq");
  endtask
  // A hang is cut short well past the roughly sixty cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      end_of_test;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    rd(32'h44, 32'h0, "state");
    rd(32'h48, 32'h0, "enable");
    rd(32'h4C, 32'h0, "flags");
    xfer(32'h48, 1'h1, 32'hFF);
    rd(32'h48, 32'hFF, "enable rw");
    xfer(32'h48, 1'h1, 32'h0D);
    $display("reset and enable test done");
    fr.frame(2'h0, 1'h0, 3'h5);
    irq_is(1'h1);
    rd(32'h44, 32'h15, "state fail");
    rd(32'h4C, 32'h08, "flag fail set");
    irq_is(1'h0);
    fr.frame(2'h1, 1'h0, 3'h0);
    irq_is(1'h1);
    rd(32'h44, 32'h0, "state clear");
    rd(32'h4C, 32'h08, "flag fail clear");
    $display("far end failure test done");
    fr.frame(2'h3, 1'h1, 3'h7);
    rd(32'h4C, 32'h04, "flag app");
    rd(32'h44, 32'h0F, "app stable");
    fr.perr;
    irq_is(1'h1);
    rd(32'h4C, 32'h01, "flag parity");
    $display("app id and parity test done");
    xfer(32'h48, 1'h1, 32'h0);
    fr.frame(2'h0, 1'h0, 3'h0);
    fr.perr;
    irq_is(1'h0);
    rd(32'h4C, 32'h0, "flags masked");
    rd(32'h44, 32'h10, "state masked");
    xfer(32'h48, 1'h1, 32'h08);
    fr.frame(2'h2, 1'h0, 3'h0);
    irq_is(1'h1);
    xfer(32'h4C, 1'h1, 32'h08);
    irq_is(1'h0);
    xfer(32'h44, 1'h1, 32'hFF);
    rd(32'h44, 32'h0, "state read only");
    rd(32'h50, 32'h0, "unmapped");
    $display("masking and access test done");
    end_of_test;
  end
endmodule // rxa_irq_test
